// *** hw/bsau_pkg.sv ***
// Constants, field layouts and types for the bit shift array unit.
// Assumes an APB master with 32-bit data on the same clock as the unit.
//
// Summary of operation
// [RQ1] Unload flag, status bit 10, holds the bit last shifted out.
// [RQ2] Error flag, status bit 11, set on a negative length value.
// [RQ3] Done flag, status bit 13, set once the array shifted one place.
// [RQ4] Armed flag, status bit 15, set on each false-to-true rung edge; the code ignores edges while the major fault is set.
// [RQ5] Rung falling after a shift clears armed, done and error flags.
// [RQ6] Size word holds array length in bits, at most 1680.
// [RQ7] Length zero copies the source bit straight into the unload flag.
// [RQ8] Length running past the allocated file raises a sticky major fault.
// [RQ9] Bits past the last array bit up to the word boundary are cleared.
// [RQ10] Every shift writes zero into the index word.
// [RQ11] Toward-MSB: bits move up, source enters bit 0, top bit unloads.
// [RQ12] Toward-LSB: bits move down, source enters top bit, bit 0 unloads.
// [RQ13] Exactly one single-place shift per trigger, finished before next access.
// [RQ14] Program picks unload flag or shifted-out bit as source to circulate.
// [RQ15] Program ignores the unload flag while the error flag is set.
// [RQ16] Previous rung level is held so only a rising edge triggers.

package bsau_pkg;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam int ADDR_W = 12;
	localparam logic [11:0] A_STATUS = 12'h000;
	localparam logic [11:0] A_SIZE = 12'h004;
	localparam logic [11:0] A_SPARE = 12'h008;
	localparam logic [11:0] A_CTRL = 12'h00C;
	localparam logic [11:0] A_INDEX = 12'h010;
	localparam logic [11:0] A_FAULT = 12'h014;
	localparam logic [11:0] A_FILE = 12'h018;
	localparam logic [11:0] A_ARRAY = 12'h400;

	// ----------------------------------------
	// Sizes and reset values
	// ----------------------------------------
	localparam int WORD_W = 16;
	localparam int ARRAY_WORDS = 105;
	localparam logic [15:0] MAX_BITS = 16'h0690;
	localparam logic [15:0] STATUS_RST = 16'h0000;
	localparam logic [15:0] SIZE_RST = 16'h0000;
	localparam logic [15:0] INDEX_RST = 16'h0000;
	localparam logic [15:0] FILE_RST = 16'h0069;
	localparam logic [15:0] ONE_W = 16'h0001;
	localparam logic [3:0] TOP_BIT = 4'hF;
	localparam logic [15:0] ALL_ONES = 16'hFFFF;

	// ----------------------------------------
	// Packed carriers
	// ----------------------------------------
	typedef struct packed {
		logic armed;
		logic unused14;
		logic done;
		logic unused12;
		logic error;
		logic unload;
		logic [9:0] unused;
	} bsau_status_s;

	typedef struct packed {
		logic [12:0] unused;
		logic source;
		logic toward_lsb;
		logic rung;
	} bsau_ctrl_s;

	typedef enum logic [1:0] {
		BSAU_IDLE,
		BSAU_RD,
		BSAU_WR
	} bsau_state_e;

endpackage

// *** hw/bsau_bit_mem.sv ***
// Word memory that holds the bit array.
// Assumes one port, write and read in the same cycle returns old data.
`timescale 1ns/1ps

module bsau_bit_mem #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 105,
	parameter int AW = 7
) (
	// Clock
	input wire logic clk_sys,
	// Access port
	input wire logic we,
	input wire logic [AW-1:0] addr,
	input wire logic [WIDTH-1:0] wdata,
	output logic [WIDTH-1:0] rdata_r
);

	logic [WIDTH-1:0] mem [DEPTH];

	always_ff @(posedge clk_sys) begin
		if (we) begin
			mem[addr] <= wdata;
		end
		rdata_r <= mem[addr];
	end

endmodule

// *** hw/bsau_top.sv ***
// Bit shift array unit with APB register access.
// Assumes an APB master on clk_sys; array words are mapped after the
// control registers and shifts run word by word through the memory.
//
// Design decisions made here: the placing of the registers and the APB register port.
`timescale 1ns/1ps

module bsau_top #(
	parameter int DEPTH = bsau_pkg::ARRAY_WORDS,
	parameter logic [15:0] MAX_LEN = bsau_pkg::MAX_BITS
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata_r,
	output logic pready_r,
	output logic pslverr_r,
	// Status outputs
	output logic unload_flag_r,
	output logic major_fault_r,
	output logic busy_r
);

	localparam int AW = $clog2(DEPTH);
	localparam logic [3:0] LSB4 = 4'h0;

	// ----------------------------------------
	// Registers and state
	// ----------------------------------------
	bsau_pkg::bsau_status_s status_r;
	bsau_pkg::bsau_ctrl_s ctrl_r;
	bsau_pkg::bsau_state_e state_r;
	logic [15:0] size_r;
	logic [15:0] index_r;
	logic [15:0] file_r;
	logic rung_prev_r;
	logic apb_wait_r;
	logic [AW-1:0] ptr_r;
	logic [AW-1:0] lastw_r;
	logic [3:0] lastb_r;
	logic dir_r;
	logic carry_r;

	// ----------------------------------------
	// Memory port
	// ----------------------------------------
	logic mem_we;
	logic [AW-1:0] mem_addr;
	logic [15:0] mem_wdata;
	logic [15:0] mem_rdata;

	bsau_bit_mem #(
		.WIDTH(bsau_pkg::WORD_W),
		.DEPTH(DEPTH),
		.AW(AW)
	) u_mem (
		.clk_sys(clk_sys),
		.we(mem_we),
		.addr(mem_addr),
		.wdata(mem_wdata),
		.rdata_r(mem_rdata)
	);

	// ----------------------------------------
	// APB decode
	// ----------------------------------------
	logic idle;
	logic access;
	logic apb_go;
	logic commit;
	logic [11:0] arr_off;
	logic arr_hit;
	logic reg_hit;
	logic [AW-1:0] arr_idx;
	logic [31:0] rd_val;

	assign idle = (state_r == bsau_pkg::BSAU_IDLE);
	assign access = psel & penable;
	assign apb_go = access & ~pready_r & idle;
	assign commit = access & pready_r & pwrite;
	assign arr_off = paddr - bsau_pkg::A_ARRAY;
	assign arr_idx = arr_off[AW+1:2];
	assign arr_hit = (paddr >= bsau_pkg::A_ARRAY)
		&& (arr_off[1:0] == 2'h0)
		&& ({2'h0, arr_off[11:2]} < 12'(DEPTH));

	always_comb begin
		reg_hit = 1'b1;
		rd_val = 32'h0000_0000;
		case (paddr)
			bsau_pkg::A_STATUS: rd_val = {16'h0000, status_r};
			bsau_pkg::A_SIZE: rd_val = {16'h0000, size_r};
			bsau_pkg::A_SPARE: rd_val = 32'h0000_0000;
			bsau_pkg::A_CTRL: rd_val = {16'h0000, ctrl_r};
			bsau_pkg::A_INDEX: rd_val = {16'h0000, index_r};
			bsau_pkg::A_FAULT: rd_val = {31'h0000_0000, major_fault_r};
			bsau_pkg::A_FILE: rd_val = {16'h0000, file_r};
			default: begin
				reg_hit = 1'b0;
				rd_val = {16'h0000, mem_rdata};
			end
		endcase
	end

	// ----------------------------------------
	// APB answer
	// ----------------------------------------
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= 32'h0000_0000;
			apb_wait_r <= 1'b0;
		end else begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			if (apb_go) begin
				if (arr_hit && !pwrite && !apb_wait_r) begin
					apb_wait_r <= 1'b1;
				end else begin
					apb_wait_r <= 1'b0;
					pready_r <= 1'b1;
					pslverr_r <= ~(reg_hit | arr_hit);
					prdata_r <= (pwrite || !(reg_hit | arr_hit)) ? 32'h0000_0000 : rd_val;
				end
			end
		end
	end

	// ----------------------------------------
	// Trigger decode
	// ----------------------------------------
	logic wr_status;
	logic wr_ctrl;
	logic rise;
	logic fall;
	logic trig;
	logic len_neg;
	logic len_over;
	logic len_zero;
	logic [11:0] need_words;
	logic [15:0] sz_m1;

	assign wr_status = commit && (paddr == bsau_pkg::A_STATUS);
	assign wr_ctrl = commit && (paddr == bsau_pkg::A_CTRL);
	assign rise = ctrl_r.rung & ~rung_prev_r;
	assign fall = ~ctrl_r.rung & rung_prev_r;
	assign trig = rise & idle & ~major_fault_r;
	assign sz_m1 = size_r - bsau_pkg::ONE_W;
	assign need_words = size_r[15:4] + {11'h000, |size_r[3:0]};
	assign len_neg = size_r[15]; // RQ2
	assign len_over = (size_r > MAX_LEN) // RQ6
		|| ({4'h0, need_words} > file_r); // RQ8
	assign len_zero = (size_r == bsau_pkg::SIZE_RST);

	// ----------------------------------------
	// Shift datapath
	// ----------------------------------------
	logic at_last;
	logic fin;
	logic out_bit;
	logic [15:0] keep_m;
	logic [15:0] new_word;

	assign at_last = (ptr_r == lastw_r);
	assign keep_m = bsau_pkg::ALL_ONES >> (bsau_pkg::TOP_BIT - lastb_r);
	assign fin = (state_r == bsau_pkg::BSAU_WR)
		&& (dir_r ? (ptr_r == '0) : at_last);

	always_comb begin
		out_bit = 1'b0;
		new_word = mem_rdata;
		if (!dir_r) begin
			// Source enters low end, top array bit leaves
			new_word = {mem_rdata[14:0], carry_r}; // RQ11
			out_bit = mem_rdata[15];
			if (at_last) begin
				out_bit = mem_rdata[lastb_r]; // RQ11
				new_word = new_word & keep_m; // RQ9
			end
		end else begin
			// Source enters top array bit, bit 0 leaves
			out_bit = mem_rdata[0]; // RQ12
			new_word = {carry_r, mem_rdata[15:1]};
			if (at_last) begin
				new_word = ((mem_rdata >> 1) & (keep_m >> 1)) // RQ9
					| ({15'h0000, carry_r} << lastb_r); // RQ12
			end
		end
	end

	always_comb begin
		mem_we = 1'b0;
		mem_addr = arr_idx;
		mem_wdata = pwdata[15:0];
		if (!idle) begin
			mem_addr = ptr_r;
			mem_we = (state_r == bsau_pkg::BSAU_WR);
			mem_wdata = new_word;
		end else if (commit && arr_hit) begin
			mem_we = 1'b1;
		end
	end

	// ----------------------------------------
	// Shift sequencer
	// ----------------------------------------
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state_r <= bsau_pkg::BSAU_IDLE;
			ptr_r <= '0;
			lastw_r <= '0;
			lastb_r <= LSB4;
			dir_r <= 1'b0;
			carry_r <= 1'b0;
		end else begin
			case (state_r)
				bsau_pkg::BSAU_IDLE: begin
					if (trig && !len_neg && !len_over && !len_zero) begin // RQ13
						lastw_r <= sz_m1[AW+3:4];
						lastb_r <= sz_m1[3:0];
						dir_r <= ctrl_r.toward_lsb;
						carry_r <= ctrl_r.source;
						ptr_r <= ctrl_r.toward_lsb ? sz_m1[AW+3:4] : '0;
						state_r <= bsau_pkg::BSAU_RD;
					end
				end
				bsau_pkg::BSAU_RD: begin
					state_r <= bsau_pkg::BSAU_WR;
				end
				bsau_pkg::BSAU_WR: begin
					carry_r <= out_bit;
					if (fin) begin
						state_r <= bsau_pkg::BSAU_IDLE;
					end else begin
						ptr_r <= dir_r ? ptr_r - 1'b1 : ptr_r + 1'b1;
						state_r <= bsau_pkg::BSAU_RD;
					end
				end
				default: begin
					state_r <= bsau_pkg::BSAU_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			busy_r <= 1'b0;
		end else begin
			busy_r <= (trig && !len_neg && !len_over && !len_zero)
				|| (!idle && !fin);
		end
	end

	// ----------------------------------------
	// Rung edge tracking
	// ----------------------------------------
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			rung_prev_r <= 1'b0;
		end else if (idle) begin
			rung_prev_r <= ctrl_r.rung; // RQ16
		end
	end

	// ----------------------------------------
	// Status word
	// ----------------------------------------
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			status_r <= bsau_pkg::STATUS_RST;
		end else begin
			if (wr_status) begin
				status_r.armed <= pwdata[15];
				status_r.done <= pwdata[13];
				status_r.error <= pwdata[11];
				status_r.unload <= pwdata[10];
			end
			if (fall && idle) begin
				status_r.armed <= 1'b0; // RQ5
				status_r.done <= 1'b0; // RQ5
				status_r.error <= 1'b0; // RQ5
			end
			if (trig) begin
				status_r.armed <= 1'b1; // RQ4
				if (len_neg) begin
					status_r.error <= 1'b1; // RQ2
				end else if (len_zero) begin
					status_r.unload <= ctrl_r.source; // RQ7
					status_r.done <= 1'b1; // RQ3
				end
			end
			if (fin) begin
				status_r.unload <= out_bit; // RQ1
				status_r.done <= 1'b1; // RQ3
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			unload_flag_r <= 1'b0;
		end else if (fin) begin
			unload_flag_r <= out_bit; // RQ1
		end else if (trig && len_zero && !len_neg) begin
			unload_flag_r <= ctrl_r.source;
		end else if (wr_status) begin
			unload_flag_r <= pwdata[10];
		end
	end

	// ----------------------------------------
	// Control, size and file words
	// ----------------------------------------
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ctrl_r <= '0;
		end else if (wr_ctrl) begin
			ctrl_r.rung <= pwdata[0];
			ctrl_r.toward_lsb <= pwdata[1];
			ctrl_r.source <= pwdata[2];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			size_r <= bsau_pkg::SIZE_RST;
		end else if (commit && paddr == bsau_pkg::A_SIZE) begin
			size_r <= pwdata[15:0]; // RQ6
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			file_r <= bsau_pkg::FILE_RST;
		end else if (commit && paddr == bsau_pkg::A_FILE) begin
			file_r <= pwdata[15:0];
		end
	end

	// ----------------------------------------
	// Index word
	// ----------------------------------------
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			index_r <= bsau_pkg::INDEX_RST;
		end else if (fin || (trig && len_zero && !len_neg)) begin
			index_r <= bsau_pkg::INDEX_RST; // RQ10
		end else if (commit && paddr == bsau_pkg::A_INDEX) begin
			index_r <= pwdata[15:0];
		end
	end

	// ----------------------------------------
	// Major fault, sticky, write 1 clears
	// ----------------------------------------
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			major_fault_r <= 1'b0;
		end else if (trig && !len_neg && len_over) begin
			major_fault_r <= 1'b1; // RQ8
		end else if (commit && paddr == bsau_pkg::A_FAULT && pwdata[0]) begin
			major_fault_r <= 1'b0;
		end
	end

endmodule

// *** tb/bsau_top_asserts.sv ***
// Port checker for the bit shift array unit.
// Assumes a bind to bsau_top; one clock, synchronous reset.
`timescale 1ns/1ps

module bsau_top_asserts #(
	parameter int DEPTH = 105,
	parameter logic [15:0] MAX_LEN = 16'h0690
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata_r,
	input wire logic pready_r,
	input wire logic pslverr_r,
	// Status
	input wire logic unload_flag_r,
	input wire logic major_fault_r,
	input wire logic busy_r
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);

	property p_rdy_pulse;
		pready_r |=> !pready_r;
	endproperty
	a_rdy_pulse: assert property (p_rdy_pulse) else $error("ready held");
	property p_rdy_acc;
		pready_r |-> psel && penable;
	endproperty
	a_rdy_acc: assert property (p_rdy_acc) else $error("ready outside access");
	property p_err_zero;
		pslverr_r |-> pready_r && prdata_r == 32'h00000000;
	endproperty
	a_err_zero: assert property (p_err_zero) else $error("bad refusal");
	property p_answer;
		$rose(penable) && psel |-> ##[1:400] pready_r;
	endproperty
	a_answer: assert property (p_answer) else $error("no answer");
	property p_busy_end;
		$rose(busy_r) |-> ##[1:300] !busy_r;
	endproperty
	a_busy_end: assert property (p_busy_end) else $error("shift too long");
	property p_fault_hold;
		major_fault_r && !(psel && penable && pready_r && pwrite && paddr == bsau_pkg::A_FAULT
			&& pwdata[0]) |=> major_fault_r;
	endproperty
	a_fault_hold: assert property (p_fault_hold) else $error("fault lost");
	property p_unl_quiet;
		!psel [*4] ##0 !busy_r && !$past(busy_r) |=> $stable(unload_flag_r);
	endproperty
	a_unl_quiet: assert property (p_unl_quiet) else $error("unload moved");
	property p_rst;
		disable iff (1'b0) rst |=> !pready_r && !unload_flag_r && !major_fault_r && !busy_r;
	endproperty
	a_rst: assert property (p_rst) else $error("reset values");
endmodule

// *** tb/bsau_prog_model.sv ***
// Ladder program model: APB master issuing register writes and rungs.
// Assumes bsau_top_tb holds error_cnt and close_out.
`timescale 1ns/1ps

module bsau_prog_model (
	// Clock
	input wire logic clk_sys,
	// APB master
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [11:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata_r,
	input wire logic pready_r,
	input wire logic pslverr_r
);
	logic [31:0] rdat;
	logic rerr;

	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h00000000;
	end

	task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do begin
			@(posedge clk_sys);
			n++;
		end while (pready_r !== 1'b1 && n < 400);
		if (n >= 400) begin
			bsau_top_tb.error_cnt++;
			bsau_top_tb.close_out();
		end
		rdat = prdata_r;
		rerr = pslverr_r;
		psel <= 1'b0;
		penable <= 1'b0;
		// Released address and data lines do not keep the last value
		paddr <= ~a;
		pwdata <= ~d;
	endtask

	// Rung low then high; caller picks mode and source
	task automatic trig(input logic [2:0] c);
		xfer(1'b1, bsau_pkg::A_CTRL, {29'h0, c & 3'h6});
		xfer(1'b1, bsau_pkg::A_CTRL, {29'h0, c | 3'h1});
	endtask
endmodule

// *** tb/bsau_top_tb.sv ***
// Self-checking bench for the bit shift array unit.
// Assumes the program model as APB master; checker bound at the foot.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin error_cnt++; \
	$display("CHECK FAILED %s exp %h got %h", nm, ex, got); end end

module bsau_top_tb;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	wire logic psel, penable, pwrite, pready_r, pslverr_r, unload_flag_r, major_fault_r, busy_r;
	wire logic [11:0] paddr;
	wire logic [31:0] pwdata, prdata_r;
	int error_cnt = 0;
	int cmp_count = 0;
	localparam logic [11:0] ST = bsau_pkg::A_STATUS;
	localparam logic [11:0] SZ = bsau_pkg::A_SIZE;
	localparam logic [11:0] AR = bsau_pkg::A_ARRAY;

	always #5 clk_sys = ~clk_sys;

	bsau_top u_dut (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_r(prdata_r),
		.pready_r(pready_r), .pslverr_r(pslverr_r), .unload_flag_r(unload_flag_r),
		.major_fault_r(major_fault_r), .busy_r(busy_r));
	bsau_prog_model u_prog (.clk_sys(clk_sys), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_r(prdata_r),
		.pready_r(pready_r), .pslverr_r(pslverr_r));

	task automatic w(input logic [11:0] a, input logic [15:0] d);
		u_prog.xfer(1'b1, a, {16'h0000, d});
	endtask
	task automatic r(input logic [11:0] a, input logic [31:0] e, input string nm);
		u_prog.xfer(1'b0, a, 32'h00000000);
		`CHK(nm, e, u_prog.rdat)
	endtask

	task t_msb;
		r(ST, 32'h00000000, "st");
		w(bsau_pkg::A_SPARE, 16'hFFFF);
		r(bsau_pkg::A_SPARE, 32'h00000000, "spare");
		w(SZ, 16'h0014);
		w(AR, 16'h8001);
		w(AR + 12'h004, 16'h00F7);
		w(bsau_pkg::A_INDEX, 16'h0005);
		u_prog.trig(3'h4);
		r(ST, 32'h0000A000, "st");
		r(AR, 32'h00000003, "a0");
		r(AR + 12'h004, 32'h0000000F, "a1");
		r(bsau_pkg::A_INDEX, 32'h00000000, "ix");
		w(bsau_pkg::A_CTRL, 16'h0005);
		r(AR, 32'h00000003, "a0");
		w(bsau_pkg::A_CTRL, 16'h0004);
		r(ST, 32'h00000000, "st");
	endtask

	task t_lsb_zero;
		u_prog.trig(3'h2);
		r(ST, 32'h0000A400, "st");
		r(AR, 32'h00008001, "a0");
		r(AR + 12'h004, 32'h00000007, "a1");
		`CHK("ul", 1'b1, unload_flag_r)
		w(SZ, 16'h0000);
		u_prog.trig(3'h0);
		r(AR, 32'h00008001, "a0");
		`CHK("ul", 1'b0, unload_flag_r)
		u_prog.trig(3'h4);
		r(ST, 32'h0000A400, "st");
	endtask

	task t_errs;
		w(SZ, 16'h8000);
		u_prog.trig(3'h0);
		r(ST, 32'h00008C00, "st");
		w(bsau_pkg::A_CTRL, 16'h0000);
		r(ST, 32'h00000400, "st");
		w(SZ, 16'h0691);
		u_prog.trig(3'h0);
		r(AR, 32'h00008001, "a0");
		`CHK("mf", 1'b1, major_fault_r)
		w(bsau_pkg::A_FAULT, 16'h0001);
		r(bsau_pkg::A_FAULT, 32'h00000000, "ft");
		w(bsau_pkg::A_FILE, 16'h0001);
		w(SZ, 16'h0011);
		u_prog.trig(3'h0);
		r(bsau_pkg::A_FAULT, 32'h00000001, "ft");
		w(bsau_pkg::A_FAULT, 16'h0001);
		w(bsau_pkg::A_FILE, 16'h0069);
		w(SZ, 16'h0690);
		w(AR + 12'h1A0, 16'h0000);
		u_prog.trig(3'h4);
		repeat (2) @(posedge clk_sys);
		`CHK("busy", 1'b1, busy_r)
		r(AR, 32'h00000003, "a0");
		`CHK("busy", 1'b0, busy_r)
		`CHK("mf", 1'b0, major_fault_r)
		`CHK("ul", 1'b0, unload_flag_r)
		u_prog.xfer(1'b0, AR + 12'h1A4, 32'h00000000);
		`CHK("err", 1'b1, u_prog.rerr)
	endtask

	task close_out;
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	initial begin
		repeat (16) @(posedge clk_sys);
		rst <= 1'b0;
		t_msb();
		t_lsb_zero();
		t_errs();
		repeat (6) @(posedge clk_sys);
		close_out();
	end
endmodule

bind bsau_top bsau_top_asserts #(.DEPTH(DEPTH), .MAX_LEN(MAX_LEN)) u_chk (.clk_sys(clk_sys),
	.rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata_r(prdata_r), .pready_r(pready_r), .pslverr_r(pslverr_r),
	.unload_flag_r(unload_flag_r), .major_fault_r(major_fault_r), .busy_r(busy_r));
